// [frc_ext_src.sv]
// External clock source model driving the timer pin
`timescale 1ns/1ps
`default_nettype none
module frc_ext_src (
	// Clock
	input wire logic clk,
	// Pin
	output logic ext_clock_pin
);
	initial ext_clock_pin = 1'b0;
	// Rises n times, falls n-1 times, edges four cycles apart
	task automatic burst(input int n);
		for (int i = 0; i < n; i++) begin
			if (i > 0) begin
				@(posedge clk) ext_clock_pin <= 1'b0;
				repeat (3) @(posedge clk);
			end
			@(posedge clk) ext_clock_pin <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	// Back to idle low
	task automatic drop();
		@(posedge clk) ext_clock_pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// [frc_monitor.sv]
// Handshake and interrupt checker for the timer counter slave port
`timescale 1ns/1ps
`default_nettype none
module frc_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [frc_pkg::FRC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// CPU state and request
	input wire logic cpu_int_mask,
	input wire logic timer_irq
);
	import frc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ****************
	// Steps of the flag clear
	// ****************
	sequence st_armed;
		avs_read && avs_waitrequest && avs_address == FRC_OFS_STATUS ##1 avs_readdata[0];
	endsequence
	sequence lo_taken;
		(avs_read || avs_write) && avs_waitrequest && avs_address == FRC_OFS_CNT_LO;
	endsequence
	// ****************
	// Assertions
	// ****************
	a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_take_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after taken request");
	a_idle_wait_high: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 5'h1c |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_mask_quiet: assert property (cpu_int_mask |=> !timer_irq)
		else $error("request while masked");
	a_irq_pending: assert property (timer_irq && !cpu_int_mask && !avs_read && !avs_write && !$past(avs_read)
		&& !$past(avs_write) |=> timer_irq)
		else $error("request dropped");
	a_alt_keeps_irq: assert property (timer_irq && !cpu_int_mask && avs_read && avs_address == FRC_OFS_ALT_LO
		|=> timer_irq)
		else $error("alternate read cleared request");
	a_clear_two_step: assert property (st_armed ##[1:4] lo_taken |-> ##[1:3] !timer_irq)
		else $error("request not cleared");
endmodule
`default_nettype wire

// [frc_pkg.sv]
// Constants and register map of the free-running 16-bit timer counter
//
// Functional notes
// - Sixteen-bit up counter, stops only in halt, fed by a prescaler of 2, 4 or 8.
// - Any write to either low byte register loads the counter with fffc; data ignored.
// - Alternate pair reads the same count; its low byte never clears overflow.
// - High byte read first captures the low byte; held until the low byte is read.
// - Low byte read outside a sequence returns the live low byte.
// - Wrap from ffff to 0000 sets the overflow flag in every mode.
// - Interrupt when flag, enable and clear cpu mask; otherwise it stays pending.
// - Flag clears after status read while set, then a main low byte access.
// - Counter, prescaler and flags keep running during wait state.
// - Halt freezes the count; interrupt wake resumes, reset wake restarts.
// - Both clock select bits high clock the counter from the external pin.
// - Edge select bit picks rising or falling external edge.
// - External clock counting is synchronised to the cpu clock.
// - A missing external pin reads internally as constant one.
package frc_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam int FRC_ADDR_W = 5;
	localparam logic [4:0] FRC_OFS_CNT_HI = 5'h00;
	localparam logic [4:0] FRC_OFS_CNT_LO = 5'h04;
	localparam logic [4:0] FRC_OFS_ALT_HI = 5'h08;
	localparam logic [4:0] FRC_OFS_ALT_LO = 5'h0c;
	localparam logic [4:0] FRC_OFS_STATUS = 5'h10;
	localparam logic [4:0] FRC_OFS_CTRL1 = 5'h14;
	localparam logic [4:0] FRC_OFS_CTRL2 = 5'h18;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int FRC_ST_TOF_BIT = 0;
	localparam int FRC_C1_OVERFLOW_IRQ_ENABLE_BIT = 0;
	localparam int FRC_C2_CS0_BIT = 0;
	localparam int FRC_C2_CS1_BIT = 1;
	localparam int FRC_C2_EDGE_BIT = 2;

	// ****************************************
	// Reset and load values
	// ****************************************
	localparam logic [15:0] FRC_CNT_RESET = 16'hfffc;
	localparam logic [15:0] FRC_CNT_LOAD = 16'hfffc;
	localparam logic [15:0] FRC_CNT_MAX = 16'hffff;
	localparam logic [2:0] FRC_CTRL2_RESET = 3'h0;

	// ****************************************
	// Clock select codes and prescaler masks
	// ****************************************
	typedef enum logic [1:0] {
		FRC_CS_DIV2 = 2'h0,
		FRC_CS_DIV4 = 2'h1,
		FRC_CS_DIV8 = 2'h2,
		FRC_CS_EXT = 2'h3
	} frc_clksel_type;
	localparam logic [2:0] FRC_MASK_DIV2 = 3'h1;
	localparam logic [2:0] FRC_MASK_DIV4 = 3'h3;
	localparam logic [2:0] FRC_MASK_DIV8 = 3'h7;

endpackage

// [frc_readbuf.sv]
// Low byte buffer for high-byte-first two-byte counter reads
`timescale 1ns/1ps
`default_nettype none
module frc_readbuf (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Access strobes
	input wire logic rd_high,
	input wire logic rd_low,
	// Live count
	input wire logic [15:0] count,
	// Low byte answer
	output logic [7:0] low_byte
);
	import frc_pkg::*;

	logic held_r;
	logic [7:0] low_hold_r;

	// Capture on first high read, release on low read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			held_r <= 1'b0;
			low_hold_r <= 8'h00;
		end else if (rd_low) begin
			held_r <= 1'b0;
		end else if (rd_high && !held_r) begin
			held_r <= 1'b1;
			low_hold_r <= count[7:0];
		end
	end

	// Held byte inside a sequence, live byte otherwise
	assign low_byte = held_r ? low_hold_r : count[7:0];

endmodule
`default_nettype wire

// [frc_tick.sv]
// Prescaler and external clock edge detector producing the counter tick
`timescale 1ns/1ps
`default_nettype none
module frc_tick #(
	parameter bit EXT_PIN_PRESENT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire frc_pkg::frc_clksel_type clk_sel,
	input wire logic ext_clock_edge_select,
	input wire logic halt_mode,
	// External pin
	input wire logic ext_clock_pin,
	// Tick out
	output logic tick
);
	import frc_pkg::*;

	logic [2:0] presc_r;
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic [2:0] prime_r;
	logic pin_in;
	logic ext_edge;

	// Division mask per clock select
	function automatic logic [2:0] presc_mask(input frc_clksel_type sel);
		unique case (sel)
			FRC_CS_DIV2: presc_mask = FRC_MASK_DIV2;
			FRC_CS_DIV4: presc_mask = FRC_MASK_DIV4;
			FRC_CS_DIV8: presc_mask = FRC_MASK_DIV8;
			FRC_CS_EXT: presc_mask = FRC_MASK_DIV8;
		endcase
	endfunction

	// Absent pin is a constant one
	assign pin_in = EXT_PIN_PRESENT ? ext_clock_pin : 1'b1;

	// Two-flop synchroniser, third flop for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Edge history trusted only once real pin samples reach the third flop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prime_r <= 3'h0;
		end else begin
			prime_r <= {prime_r[1:0], 1'b1};
		end
	end

	// Selected edge; source is slow enough to see every edge
	assign ext_edge = prime_r[2] & (ext_clock_edge_select ? (sync3_r & ~sync2_r) : (sync2_r & ~sync3_r));

	// Free-running prescaler, frozen only in halt
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= 3'h0;
		end else if (!halt_mode) begin
			presc_r <= presc_r + 3'h1;
		end
	end

	// Tick selection
	always_comb begin
		if (halt_mode) begin
			tick = 1'b0;
		end else if (clk_sel == FRC_CS_EXT) begin
			tick = ext_edge;
		end else begin
			tick = (presc_r & presc_mask(clk_sel)) == presc_mask(clk_sel);
		end
	end

endmodule
`default_nettype wire

// [frc_top.sv]
// Free-running 16-bit timer counter with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module frc_top #(
	parameter bit EXT_PIN_PRESENT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [frc_pkg::FRC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// CPU state
	input wire logic cpu_int_mask,
	input wire logic halt_mode,
	// External clock pin
	input wire logic ext_clock_pin,
	// Interrupt request
	output logic timer_irq
);
	import frc_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic timer_overflow_flag_r;
	logic clear_armed_r;
	logic overflow_irq_enable_r;
	logic [2:0] timer_control_two_r;
	logic [31:0] readdata_r;
	logic waitrequest_r;
	logic irq_r;
	logic tick;
	logic wrap;
	logic accept;
	logic rd_acc;
	logic wr_acc;
	logic hit_cnt_hi;
	logic hit_cnt_lo;
	logic hit_alt_hi;
	logic hit_alt_lo;
	logic hit_status;
	logic hit_ctrl1;
	logic hit_ctrl2;
	logic low_access;
	logic [7:0] low_byte;
	logic [31:0] rd_mux;
	frc_clksel_type clk_sel;

	// Byte-lane zero extended to a word
	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	// ****************************************
	// Bus handshake
	// ****************************************

	// Request taken while waitrequest is high
	assign accept = (avs_read | avs_write) & waitrequest_r;
	assign rd_acc = accept & avs_read;
	assign wr_acc = accept & avs_write;

	// Address decode
	assign hit_cnt_hi = avs_address == FRC_OFS_CNT_HI;
	assign hit_cnt_lo = avs_address == FRC_OFS_CNT_LO;
	assign hit_alt_hi = avs_address == FRC_OFS_ALT_HI;
	assign hit_alt_lo = avs_address == FRC_OFS_ALT_LO;
	assign hit_status = avs_address == FRC_OFS_STATUS;
	assign hit_ctrl1 = avs_address == FRC_OFS_CTRL1;
	assign hit_ctrl2 = avs_address == FRC_OFS_CTRL2;

	// One-cycle low pulse of waitrequest after each taken request
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest_r <= 1'b1;
		end else begin
			waitrequest_r <= ~accept;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************

	// Overflow interrupt enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			overflow_irq_enable_r <= 1'b0;
		end else if (wr_acc && hit_ctrl1 && avs_byteenable[0]) begin
			overflow_irq_enable_r <= avs_writedata[FRC_C1_OVERFLOW_IRQ_ENABLE_BIT];
		end
	end

	// Clock select and edge select
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_control_two_r <= FRC_CTRL2_RESET;
		end else if (wr_acc && hit_ctrl2 && avs_byteenable[0]) begin
			timer_control_two_r <= avs_writedata[2:0];
		end
	end

	// Clock select field decode
	assign clk_sel = frc_clksel_type'({timer_control_two_r[FRC_C2_CS1_BIT],
		timer_control_two_r[FRC_C2_CS0_BIT]});

	// ****************************************
	// Counter clocking
	// ****************************************

	// Prescaler and external edge source; wait state has no input here
	frc_tick #(
		.EXT_PIN_PRESENT(EXT_PIN_PRESENT)
	) u_tick (
		.clk(clk),
		.rst_b(rst_b),
		.clk_sel(clk_sel),
		.ext_clock_edge_select(timer_control_two_r[FRC_C2_EDGE_BIT]),
		.halt_mode(halt_mode),
		.ext_clock_pin(ext_clock_pin),
		.tick(tick)
	);

	// ****************************************
	// Free-running counter
	// ****************************************

	// Wrap detection
	assign wrap = tick & (count_r == FRC_CNT_MAX);

	// Any write to either low byte register
	always_comb begin
		if (wr_acc && (hit_cnt_lo || hit_alt_lo)) begin
			count_nxt = FRC_CNT_LOAD;
		end else if (tick) begin
			count_nxt = count_r + 16'h0001;
		end else begin
			count_nxt = count_r;
		end
	end

	// Count register; reset restarts from the reset count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= FRC_CNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ****************************************
	// Two-byte read buffering
	// ****************************************

	// Shared by main and alternate pairs
	frc_readbuf u_readbuf (
		.clk(clk),
		.rst_b(rst_b),
		.rd_high(rd_acc & (hit_cnt_hi | hit_alt_hi)),
		.rd_low(rd_acc & (hit_cnt_lo | hit_alt_lo)),
		.count(count_r),
		.low_byte(low_byte)
	);

	// ****************************************
	// Overflow flag and two-step clear
	// ****************************************

	// Only the main low byte takes part in clearing
	assign low_access = accept & hit_cnt_lo;

	// Status read while set arms the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clear_armed_r <= 1'b0;
		end else if (low_access) begin
			clear_armed_r <= 1'b0;
		end else if (rd_acc && hit_status && timer_overflow_flag_r) begin
			clear_armed_r <= 1'b1;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_overflow_flag_r <= 1'b0;
		end else if (wrap) begin
			timer_overflow_flag_r <= 1'b1;
		end else if (low_access && clear_armed_r) begin
			timer_overflow_flag_r <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt request
	// ****************************************

	// Pending flag issued once both enables hold
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= timer_overflow_flag_r & overflow_irq_enable_r & ~cpu_int_mask;
		end
	end

	// ****************************************
	// Read data
	// ****************************************

	// Register read multiplexer, unmapped reads zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_cnt_hi || hit_alt_hi) begin
			rd_mux = byte_word(count_r[15:8]);
		end else if (hit_cnt_lo || hit_alt_lo) begin
			rd_mux = byte_word(low_byte);
		end else if (hit_status) begin
			rd_mux[FRC_ST_TOF_BIT] = timer_overflow_flag_r;
		end else if (hit_ctrl1) begin
			rd_mux[FRC_C1_OVERFLOW_IRQ_ENABLE_BIT] = overflow_irq_enable_r;
		end else if (hit_ctrl2) begin
			rd_mux = {29'h00000000, timer_control_two_r};
		end
	end

	// Read data captured at the taking edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readdata_r <= 32'h00000000;
		end else if (rd_acc) begin
			readdata_r <= rd_mux;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Flop-driven ports
	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitrequest_r;
	assign timer_irq = irq_r;

endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the free-running timer counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import frc_pkg::*;
	logic clk, rst_b, rd, wr, mask, halt, wreq, irq, pin;
	logic [4:0] adr, ah, al;
	logic [31:0] wd, q, rdat;
	logic [7:0] l1, d;
	int num_errors = 0, n_compared = 0, w, ex, n;
	// ****************
	// Clock, design, partner
	// ****************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	frc_top frc_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.cpu_int_mask(mask), .halt_mode(halt), .ext_clock_pin(pin), .timer_irq(irq));
	frc_ext_src frc_ext_src_inst (.clk(clk), .ext_clock_pin(pin));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic bus(input logic wt_en, input logic [4:0] a, input logic [7:0] dat);
		int k;
		k = 0;
		@(posedge clk);
		rd <= !wt_en;
		wr <= wt_en;
		adr <= a;
		wd <= {24'h0, dat};
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 40);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 40) chk(0, 1, "no answer");
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		rd = 0; wr = 0; adr = 0; wd = 0; mask = 1; halt = 0; rst_b = 0;
		void'($urandom(32'hb6f380ca));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, FRC_OFS_STATUS, 0);
		chk(q[0], 0, "status reset");
		bus(0, FRC_OFS_CTRL2, 0);
		chk(q[2:0], FRC_CTRL2_RESET, "ctrl2 reset");
		bus(0, 5'h1c, 0);
		chk(q, 0, "unmapped");
		$display("test reset done");
		wt(20);
		bus(0, FRC_OFS_STATUS, 0);
		chk(q[0], 1, "overflow");
		@(posedge clk) mask <= 1'b0;
		bus(1, FRC_OFS_CTRL1, 1);
		wt(3);
		chk(irq, 1, "irq");
		@(posedge clk) mask <= 1'b1;
		wt(3);
		chk(irq, 0, "masked");
		@(posedge clk) mask <= 1'b0;
		wt(3);
		chk(irq, 1, "pending");
		bus(0, FRC_OFS_ALT_LO, 0);
		bus(0, FRC_OFS_STATUS, 0);
		chk(q[0], 1, "alt kept flag");
		bus(0, FRC_OFS_CNT_LO, 0);
		wt(3);
		chk(irq, 0, "irq cleared");
		bus(0, FRC_OFS_STATUS, 0);
		chk(q[0], 0, "flag cleared");
		$display("test overflow done");
		bus(1, FRC_OFS_CTRL2, 2);
		for (int i = 0; i < 2; i++) begin
			ah = i ? FRC_OFS_ALT_HI : FRC_OFS_CNT_HI;
			al = i ? FRC_OFS_ALT_LO : FRC_OFS_CNT_LO;
			bus(1, al, $urandom);
			bus(0, ah, 0);
			chk(q[7:0], 8'hff, "high after load");
			wt(24);
			bus(0, ah, 0);
			bus(0, al, 0);
			l1 = q[7:0];
			chk(l1 inside {8'hfc, 8'hfd}, 1, "held low");
			bus(0, al, 0);
			chk(q[7:0] != l1, 1, "live low");
		end
		$display("test read sequence done");
		for (int c = 0; c < 3; c++) begin
			w = 16 + $urandom % 48;
			bus(1, FRC_OFS_CTRL2, c);
			bus(1, FRC_OFS_CNT_LO, $urandom);
			repeat (w) @(posedge clk);
			bus(0, FRC_OFS_CNT_LO, 0);
			d = q[7:0] - 8'hfc;
			ex = (w + 2) >> (c + 1);
			chk(d >= ex - 1 && d <= ex + 1, 1, "rate");
		end
		$display("test prescaler done");
		@(posedge clk) halt <= 1'b1;
		bus(0, FRC_OFS_CNT_LO, 0);
		l1 = q[7:0];
		wt(30);
		bus(0, FRC_OFS_CNT_LO, 0);
		chk(q[7:0], l1, "halt hold");
		@(posedge clk) halt <= 1'b0;
		wt(30);
		bus(0, FRC_OFS_CNT_LO, 0);
		d = q[7:0] - l1;
		chk(d inside {[1:8]}, 1, "resume");
		$display("test halt done");
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		bus(0, FRC_OFS_CNT_HI, 0);
		chk(q[7:0], 8'hff, "reset restart");
		bus(0, FRC_OFS_CNT_LO, 0);
		chk(q[7:0] inside {8'hfc, 8'hfd}, 1, "reset low");
		$display("test mid-run reset done");
		for (int e = 0; e < 2; e++) begin
			n = 1 + $urandom % 3;
			bus(1, FRC_OFS_CTRL2, {5'h0, e[0], 2'b11});
			bus(1, FRC_OFS_CNT_LO, $urandom);
			frc_ext_src_inst.burst(n);
			wt(6);
			bus(0, FRC_OFS_CNT_LO, 0);
			chk(q[7:0], 8'hfc + (e ? n - 1 : n), "ext count");
			frc_ext_src_inst.drop();
		end
		$display("test external clock done");
		give_verdict();
	end
endmodule
bind frc_top frc_monitor frc_monitor_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq));
`default_nettype wire
